// File: dmr_pkg.sv
`default_nettype none
package dmr_pkg;
	localparam int NUM_CH = 4;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// port offsets within the controller's i/o window
	localparam logic [3:0] ADDR_CHREG_LAST = 4'h7; // address/count registers 0..7
	localparam logic [3:0] ADDR_STATUS = 4'h8; // read status / write command
	localparam logic [3:0] ADDR_SOFT_REQ = 4'h9; // write and read
	localparam logic [3:0] ADDR_MASK_SINGLE = 4'hA; // write
	localparam logic [3:0] ADDR_MODE = 4'hB; // write mode / sequential read
	localparam logic [3:0] ADDR_BYTE_PTR = 4'hC; // write clears, read sets
	localparam logic [3:0] ADDR_MASTER_CLR = 4'hD; // write clears, read gives temp
	localparam logic [3:0] ADDR_MASK_CLR = 4'hE; // write clears masks, read clears mode ctr
	localparam logic [3:0] ADDR_MASK_ALL = 4'hF; // write and read
	// field positions
	localparam int SEL_LSB = 0; // channel select bits 1-0
	localparam int SET_BIT = 2; // set/clear bit
	localparam int AUTO_RELOAD_BIT = 4; // mode byte bit 4
	// values after reset, then fixed read and bus levels
	localparam logic [3:0] SOFT_REQ_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'hF;
	localparam logic [3:0] UPPER_ONES = 4'hF; // bits 7-4 on reads
	localparam logic [1:0] MODE_SEL_ONES = 2'h3; // bits 1-0 on mode reads
	localparam logic [7:0] UNDEF_DATA = 8'hFF; // answer of read-triggered commands
	localparam logic [7:0] IDLE_BUS = 8'hFF; // undriven bus level
	localparam int READ_LAT = 1; // cycles from read strobe to data

	// update one bit of a 4-bit set from a select/set byte
	function automatic logic [3:0] sel_update(input logic [3:0] cur, input logic [7:0] d);
		logic [3:0] r;
		r = cur;
		r[d[SEL_LSB +: 2]] = d[SET_BIT];
		return r;
	endfunction

	// form a select/set byte for one channel
	function automatic logic [7:0] sel_byte(input logic [1:0] ch, input logic set);
		return {5'h00, set, ch};
	endfunction
endpackage
`default_nettype wire

// File: dmr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dmr_if;
	logic [3:0] io_addr;
	logic io_read_strobe;
	logic io_write_strobe;
	logic [7:0] host_data_out;
	logic host_data_oe;
	logic [7:0] dev_data_out;
	logic dev_data_oe;
	logic [7:0] peripheral_data_bus;

	// resolve the shared data bus from both enables
	assign peripheral_data_bus = dev_data_oe ? dev_data_out :
		(host_data_oe ? host_data_out : dmr_pkg::IDLE_BUS);

	modport device (
		input io_addr, io_read_strobe, io_write_strobe, peripheral_data_bus,
		output dev_data_out, dev_data_oe
	);
	modport host (
		output io_addr, io_read_strobe, io_write_strobe, host_data_out, host_data_oe,
		input peripheral_data_bus
	);
endinterface
`default_nettype wire

// File: dmr_host.sv
`timescale 1ns/1ns
`default_nettype none
module dmr_host (
	input wire logic clk_sys,
	input wire logic reset,
	dmr_if.host bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [3:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_data
);
	typedef enum {HS_IDLE, HS_STROBE, HS_WAIT} dmr_hstate_t;

	typedef struct packed {
		dmr_hstate_t st;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic rsp_valid;
		logic [7:0] rsp_data;
	} dmr_host_t;

	dmr_host_t s_r, s_nxt;

	// one strobe per command; reads collect data one cycle later
	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp_valid = 1'b0;
		unique case (s_r.st)
			HS_IDLE: begin
				if (cmd_valid) begin
					s_nxt.st = HS_STROBE;
					s_nxt.wr = cmd_write;
					s_nxt.addr = cmd_addr;
					s_nxt.wdata = cmd_wdata;
				end
			end
			HS_STROBE: begin
				s_nxt.st = s_r.wr ? HS_IDLE : HS_WAIT;
			end
			HS_WAIT: begin
				s_nxt.st = HS_IDLE;
				s_nxt.rsp_valid = 1'b1;
				s_nxt.rsp_data = bus.peripheral_data_bus;
			end
		endcase
		if (reset) begin
			s_nxt = '0;
			s_nxt.st = HS_IDLE;
		end
	end

	// all host state sits in one register
	always_ff @(posedge clk_sys) begin
		s_r <= s_nxt;
	end

	// strobes and bus drive follow the state
	assign cmd_ready = (s_r.st == HS_IDLE);
	assign bus.io_addr = s_r.addr;
	assign bus.io_write_strobe = (s_r.st == HS_STROBE) && s_r.wr;
	assign bus.io_read_strobe = (s_r.st == HS_STROBE) && !s_r.wr;
	assign bus.host_data_out = s_r.wdata;
	assign bus.host_data_oe = (s_r.st == HS_STROBE) && s_r.wr;
	assign rsp_valid = s_r.rsp_valid;
	assign rsp_data = s_r.rsp_data;
endmodule // dmr_host
`default_nettype wire

// File: dmr_device.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - per-channel software request bits bypass masks
// - request write: bits1-0 select, bit2 sets/clears
// - request read: bits3-0 state, 7-4 ones
// - reset clears all software requests
// - masked channel ignores external request
// - single mask write sets/clears chosen channel
// - all-mask write loads bits3-0; read ones above
// - reset or master clear sets masks
// - terminal count without auto reload masks channel
// - clear mask command clears all masks
// - status 7-4 mirror pending external requests
// - status 3-0 terminal count, cleared on read
// - memory move captures then drives temporary byte
// - commands decoded from address plus strobe
// - clear byte pointer selects low byte next
// - set byte pointer selects high byte next
// - master clear acts as hardware reset, except that stored modes, the first request sync stage and the read data byte survive it
// - mode reads walk channels 0 to 3
// - mode read returns ones in select bits
// - mode bit 4 enables auto reload
module dmr_device #(
	parameter int NUM_CH = dmr_pkg::NUM_CH
) (
	input wire logic clk_sys,
	input wire logic reset,
	dmr_if.device bus,
	input wire logic [3:0] ext_request,
	input wire logic [3:0] tc_event,
	input wire logic mm_capture,
	input wire logic mm_drive,
	output logic [3:0] service_request,
	output logic [3:0] channel_mask_bits,
	output logic [3:0] soft_request_state,
	output logic byte_pointer,
	output logic [7:0] temp_data,
	output logic master_clear_pulse
);
	typedef struct packed {
		logic [3:0] soft_req;
		logic [3:0] mask;
		logic [3:0] tc;
		logic [3:0] req_meta;
		logic [3:0] req_sync;
		logic [7:0] temp;
		logic [3:0][5:0] mode;
		logic [1:0] mode_cnt;
		logic byte_ptr;
		logic [7:0] dout;
		logic doe;
		logic mclr;
	} dmr_dev_t;

	dmr_dev_t s_r, s_nxt;
	logic rd;
	logic wr;
	logic [3:0] a;
	logic [7:0] d;

	assign rd = bus.io_read_strobe;
	assign wr = bus.io_write_strobe;
	assign a = bus.io_addr;
	assign d = bus.peripheral_data_bus;

	// decode and readback helpers

	// address/count window: every byte access there flips the pointer
	function automatic logic is_chan_reg(input logic [3:0] addr);
		return addr <= dmr_pkg::ADDR_CHREG_LAST;
	endfunction

	// auto reload option of a stored mode, bit 4 of the written byte
	function automatic logic auto_reload(input logic [5:0] mode_bits);
		return mode_bits[dmr_pkg::AUTO_RELOAD_BIT - 2];
	endfunction

	// four-bit register readback, upper half always ones
	function automatic logic [7:0] nibble_read(input logic [3:0] bits);
		return {dmr_pkg::UPPER_ONES, bits};
	endfunction

	// mode readback, channel select positions always ones
	function automatic logic [7:0] mode_read(input logic [5:0] mode_bits);
		return {mode_bits, dmr_pkg::MODE_SEL_ONES};
	endfunction

	// status byte: live pending requests above, terminal counts below
	function automatic logic [7:0] status_byte(input logic [3:0] req, input logic [3:0] tc);
		return {req, tc};
	endfunction

	// register updates, commands and read data
	always_comb begin
		s_nxt = s_r;
		s_nxt.doe = 1'b0;
		s_nxt.mclr = 1'b0;

		// two-stage synchroniser on the external request pins
		// only the second stage is read, never the first
		s_nxt.req_meta = ext_request;
		s_nxt.req_sync = s_r.req_meta;

		// host writes; the command location is not decoded here
		if (wr) begin
			if (is_chan_reg(a)) begin
				s_nxt.byte_ptr = !s_r.byte_ptr;
			end
			unique case (a)
				dmr_pkg::ADDR_SOFT_REQ: s_nxt.soft_req = dmr_pkg::sel_update(s_r.soft_req, d);
				dmr_pkg::ADDR_MASK_SINGLE: s_nxt.mask = dmr_pkg::sel_update(s_r.mask, d);
				dmr_pkg::ADDR_MASK_ALL: s_nxt.mask = d[3:0];
				dmr_pkg::ADDR_MODE: s_nxt.mode[d[1:0]] = d[7:2];
				dmr_pkg::ADDR_BYTE_PTR: s_nxt.byte_ptr = 1'b0;
				dmr_pkg::ADDR_MASK_CLR: s_nxt.mask = 4'h0;
				dmr_pkg::ADDR_MASTER_CLR: s_nxt.mclr = 1'b1;
				default: ;
			endcase
		end

		// host reads: data presented one cycle after the strobe
		// the answer stands for one cycle, then the bus is let go
		if (rd) begin
			s_nxt.doe = 1'b1;
			s_nxt.dout = dmr_pkg::UNDEF_DATA; // unmapped and command reads
			if (is_chan_reg(a)) begin
				s_nxt.byte_ptr = !s_r.byte_ptr;
			end
			unique case (a)
				dmr_pkg::ADDR_STATUS: begin
					s_nxt.dout = status_byte(s_r.req_sync, s_r.tc);
					s_nxt.tc = 4'h0; // events this cycle still win below
				end
				dmr_pkg::ADDR_SOFT_REQ: s_nxt.dout = nibble_read(s_r.soft_req);
				dmr_pkg::ADDR_MASK_ALL: s_nxt.dout = nibble_read(s_r.mask);
				dmr_pkg::ADDR_MODE: begin
					s_nxt.dout = mode_read(s_r.mode[s_r.mode_cnt]);
					s_nxt.mode_cnt = s_r.mode_cnt + 2'h1;
				end
				dmr_pkg::ADDR_BYTE_PTR: s_nxt.byte_ptr = 1'b1;
				dmr_pkg::ADDR_MASTER_CLR: s_nxt.dout = s_r.temp;
				dmr_pkg::ADDR_MASK_CLR: s_nxt.mode_cnt = 2'h0;
				default: ;
			endcase
		end

		// memory-to-memory first cycle loads the temporary byte
		// the second cycle's drive is a plain mux at the outputs
		if (mm_capture) begin
			s_nxt.temp = d;
		end

		// terminal count events win over a same-cycle status-read clear
		// placed after the read path so a status read cannot lose an event
		// the mask set also overrides a host mask write in the same cycle
		for (int i = 0; i < NUM_CH; i++) begin
			if (tc_event[i]) begin
				s_nxt.tc[i] = 1'b1;
				if (!auto_reload(s_r.mode[i])) begin
					s_nxt.mask[i] = 1'b1;
				end
			end
		end

		// master clear or reset: same effect
		// master clear lands the cycle after its strobe, so a host write
		// in that very cycle is undone; the host spaces its commands
		if (reset || s_r.mclr) begin
			s_nxt.soft_req = dmr_pkg::SOFT_REQ_RST;
			s_nxt.mask = dmr_pkg::MASK_RST;
			s_nxt.tc = 4'h0;
			s_nxt.req_sync = 4'h0;
			s_nxt.temp = 8'h00;
			s_nxt.mode_cnt = 2'h0;
			s_nxt.byte_ptr = 1'b0;
			s_nxt.doe = 1'b0;
			s_nxt.mclr = 1'b0;
		end
		// hardware reset only: modes survive a master clear
		if (reset) begin
			s_nxt.req_meta = 4'h0;
			s_nxt.mode = '0;
			s_nxt.dout = 8'h00;
		end
	end

	// all device state sits in one register
	always_ff @(posedge clk_sys) begin
		s_r <= s_nxt;
	end

	// pending external requests that the mask lets through
	logic [3:0] ext_pending;
	assign ext_pending = s_r.req_sync & ~s_r.mask;

	// external requests gated by mask, software ones never
	assign service_request = ext_pending | s_r.soft_req;

	// register views for the rest of the controller
	assign channel_mask_bits = s_r.mask;
	assign soft_request_state = s_r.soft_req;
	assign byte_pointer = s_r.byte_ptr;
	assign temp_data = s_r.temp;
	assign master_clear_pulse = s_r.mclr;
	// second memory cycle drives the temporary byte back
	assign bus.dev_data_oe = s_r.doe || mm_drive;
	assign bus.dev_data_out = mm_drive ? s_r.temp : s_r.dout;
endmodule // dmr_device
`default_nettype wire

// File: dmr_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dmr_sva (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] io_addr,
	input wire logic io_read_strobe,
	input wire logic io_write_strobe,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic [7:0] peripheral_data_bus
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// bus answers and strobe discipline
	a_read_answer: assert property (
		io_read_strobe |=> dev_data_oe) else $error("read data late");
	a_soft_upper: assert property (
		io_read_strobe && io_addr == dmr_pkg::ADDR_SOFT_REQ |=> peripheral_data_bus[7:4] == 4'hF)
		else $error("request read upper bits");
	a_mask_upper: assert property (
		io_read_strobe && io_addr == dmr_pkg::ADDR_MASK_ALL |=> peripheral_data_bus[7:4] == 4'hF)
		else $error("mask read upper bits");
	a_mode_sel: assert property (
		io_read_strobe && io_addr == dmr_pkg::ADDR_MODE |=> peripheral_data_bus[1:0] == 2'h3)
		else $error("mode read select bits");
	a_write_drive: assert property (
		io_write_strobe |-> host_data_oe) else $error("write without data");
	a_strobe_excl: assert property (
		!(io_read_strobe && io_write_strobe)) else $error("both strobes");
	a_read_single: assert property (
		io_read_strobe |=> !io_read_strobe) else $error("read strobe too long");
	a_write_single: assert property (
		io_write_strobe |=> !io_write_strobe) else $error("write strobe too long");
	c_mode_read: cover property (io_read_strobe && io_addr == dmr_pkg::ADDR_MODE);
	c_master_clr: cover property (io_write_strobe && io_addr == dmr_pkg::ADDR_MASTER_CLR);
	c_status_read: cover property (io_read_strobe && io_addr == dmr_pkg::ADDR_STATUS);
endmodule // dmr_sva
`default_nettype wire

// File: dmr_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("BAD %0t %h %h", $time, g, e); end end
module testbench;
	logic clk_sys = 0, reset = 1, cmd_valid = 0, cmd_write = 0, cmd_ready, rsp_valid;
	logic mm_capture = 0, mm_drive = 0, cap_on = 0, byte_pointer, master_clear_pulse;
	logic [3:0] cmd_addr = 0, ext_request = 0, tc_event = 0, service_request;
	logic [3:0] channel_mask_bits, soft_request_state;
	logic [7:0] cmd_wdata = 0, rsp_data, temp_data, r, exp_v;
	logic [7:0] expq[$];
	int fails = 0, check_count = 0, mclr_seen = 0;
	dmr_if bus_if();
	dmr_host dmr_host_inst (.clk_sys, .reset, .bus(bus_if), .cmd_valid, .cmd_ready,
		.cmd_write, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_data);
	dmr_device dmr_device_inst (.clk_sys, .reset, .bus(bus_if), .ext_request, .tc_event,
		.mm_capture, .mm_drive, .service_request, .channel_mask_bits, .soft_request_state,
		.byte_pointer, .temp_data, .master_clear_pulse);
	dmr_sva dmr_sva_inst (.clk_sys, .reset, .io_addr(bus_if.io_addr),
		.io_read_strobe(bus_if.io_read_strobe), .io_write_strobe(bus_if.io_write_strobe),
		.host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe),
		.peripheral_data_bus(bus_if.peripheral_data_bus));
	// clock
	always #5 clk_sys = ~clk_sys;
	// compare each read answer with the oldest note
	always @(posedge clk_sys) if (rsp_valid === 1'b1) begin
		if (expq.size() == 0) `CHK(expq.size(), 1)
		else begin
			exp_v = expq.pop_front();
			`CHK(rsp_data, exp_v)
		end
	end
	// count master clear pulses while they stand
	always @(posedge clk_sys) if (master_clear_pulse === 1'b1) mclr_seen++;
	task close_out;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one host command, spaced for reads and writes
	task automatic cmd(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n = 0;
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 50) begin
			fails++;
			close_out();
		end
		cmd_valid = 1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge clk_sys);
		cmd_valid = 0;
		mm_capture = cap_on;
		@(negedge clk_sys);
		mm_capture = 0;
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cmd(1, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		expq.push_back(e);
		cmd(0, a, 8'h00);
	endtask
	// main sequence
	initial begin
		r = 8'($urandom(68443));
		repeat (16) @(negedge clk_sys);
		reset = 0;
		rd(4'h9, 8'hF0);
		rd(4'hF, 8'hFF);
		$display("reset test done");
		for (int c = 0; c < 4; c++) begin
			r = 8'($urandom);
			wr(4'h9, {r[7:3], 1'b1, c[1:0]});
			`CHK(service_request[c], 1'b1)
		end
		rd(4'h9, 8'hFF);
		wr(4'h9, 8'hFA);
		rd(4'h9, 8'hFB);
		`CHK(soft_request_state, 4'hB)
		$display("request test done");
		r = 8'($urandom);
		wr(4'hF, r);
		rd(4'hF, {4'hF, r[3:0]});
		wr(4'hA, 8'h05);
		wr(4'hA, 8'h03);
		rd(4'hF, {4'hF, (r[3:0] | 4'h2) & 4'h7});
		wr(4'hE, r);
		rd(4'hF, 8'hF0);
		wr(4'hF, 8'h03);
		ext_request = 4'($urandom);
		repeat (4) @(negedge clk_sys);
		`CHK(service_request, (ext_request & 4'hC) | 4'hB)
		rd(4'h8, {ext_request, 4'h0});
		$display("mask test done");
		for (int c = 0; c < 4; c++) wr(4'hB, {3'h4, ~c[0], 2'h0, c[1:0]});
		wr(4'hE, 8'h00);
		tc_event = 4'hF;
		@(negedge clk_sys);
		tc_event = 0;
		@(negedge clk_sys);
		`CHK(channel_mask_bits, 4'hA)
		rd(4'h8, {ext_request, 4'hF});
		rd(4'h8, {ext_request, 4'h0});
		rd(4'hE, 8'hFF);
		for (int c = 0; c < 4; c++) rd(4'hB, {3'h4, ~c[0], 4'h3});
		$display("status and mode test done");
		rd(4'hC, 8'hFF);
		`CHK(byte_pointer, 1'b1)
		wr(4'h0, r);
		`CHK(byte_pointer, 1'b0)
		rd(4'hC, 8'hFF);
		wr(4'hC, r);
		`CHK(byte_pointer, 1'b0)
		r = 8'($urandom);
		cap_on = 1;
		wr(4'h1, r);
		cap_on = 0;
		`CHK(temp_data, r)
		mm_drive = 1;
		#1 `CHK(bus_if.peripheral_data_bus, r)
		mm_drive = 0;
		rd(4'hD, r);
		$display("pointer and temp test done");
		wr(4'hD, 8'h00);
		`CHK({channel_mask_bits, temp_data}, 12'hF00)
		`CHK(mclr_seen, 1)
		rd(4'h9, 8'hF0);
		ext_request = 0;
		repeat (4) @(negedge clk_sys);
		rd(4'h8, 8'h00);
		repeat (8) @(negedge clk_sys);
		`CHK(expq.size(), 0)
		$display("master clear test done");
		close_out();
	end
endmodule // testbench
`default_nettype wire
